/* File: hw/stpo_consts.svh */
// constants for the scheduled payload offset block
`ifndef STPO_CONSTS_SVH
`define STPO_CONSTS_SVH
`define STPO_NUM_OUTPUTS 4
`define STPO_SEL_W 2
`define STPO_OFS_W 25
`define STPO_UNIT_W 3
`define STPO_IMM_MAX 25'h098967F
`define STPO_SCH_MAX 25'h001869F
`define STPO_OFS_RESET 25'h0000000
`define STPO_UNIT_RESET 3'h0
`endif

/* File: hw/stpo_pkg.sv */
// types for the scheduled payload offset block
`include "stpo_consts.svh"
package stpo_pkg;
   typedef struct packed {
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hour;
   } stpo_time_t;
   typedef struct packed {
      logic [13:0] year;
      logic [3:0] month;
      logic [4:0] day;
   } stpo_date_t;
   typedef struct packed {
      logic signed [`STPO_OFS_W-1:0] value;
      logic [`STPO_UNIT_W-1:0] unit;
   } stpo_offset_t;
   typedef struct packed {
      stpo_offset_t pending;
      stpo_offset_t applied;
      stpo_time_t schedTime;
      stpo_date_t schedDate;
      logic armed;
      logic immFlag;
   } stpo_chan_t;
   typedef struct packed {
      stpo_chan_t [`STPO_NUM_OUTPUTS-1:0] chan;
      stpo_offset_t viewOfs;
      logic viewArm;
      logic viewImm;
      logic [`STPO_NUM_OUTPUTS-1:0] appliedPulse;
      stpo_offset_t [`STPO_NUM_OUTPUTS-1:0] payloadOfs;
   } stpo_state_t;
endpackage

/* File: hw/stpo_top.sv */
// per-output scheduled and immediate payload offset control
// How it works
// - each output keeps its own settings; selector picks one for access
// - immediate pending offset accepted in -9999999..+9999999 with unit
// - pending writes made while armed are limited to -99999..+99999 with unit
// - immediate flag On copies pending offset into selected payload field
// - while armed, immediate flag is forced off and ignored
// - each output holds scheduled time h:m:s and date y:m:d
// - armed and schedule reached: apply pending, then clear arm itself
// - read-only applied view follows pending after scheduled apply
// - clearing immediate flag keeps offset; only applying zero removes it
// - configuring schedule settings disables immediate mechanism
// - offset goes into offset field of the outgoing payload
`timescale 1ns/100ps
`include "stpo_consts.svh"
module stpo_top #(
   parameter int NUM_OUTPUTS = `STPO_NUM_OUTPUTS
) (
   input wire logic clk, // 100 MHz clock
   input wire logic reset_n, // async reset, active low
   input wire logic [`STPO_SEL_W-1:0] outputSelector, // output being accessed
   input wire logic [NUM_OUTPUTS-1:0] outputEnable, // per output enable
   input wire logic pendingWrite, // pulse: write pending offset
   input wire stpo_pkg::stpo_offset_t pendingOffsetValue, // offset and unit
   input wire logic immFlagWrite, // pulse: write immediate flag
   input wire logic immediateApplyFlag, // immediate flag value
   input wire logic schedWrite, // pulse: write schedule time and date
   input wire stpo_pkg::stpo_time_t scheduledApplyTime, // apply time
   input wire stpo_pkg::stpo_date_t scheduledApplyDate, // apply date
   input wire logic armWrite, // pulse: write arm flag
   input wire logic scheduledApplyArm, // arm flag value
   input wire stpo_pkg::stpo_time_t localTime, // local time, same clock
   input wire stpo_pkg::stpo_date_t localDate, // local date, same clock
   output stpo_pkg::stpo_offset_t appliedOffsetView, // applied offset, selected output
   output logic armView, // arm flag, selected output
   output logic immView, // immediate flag, selected output
   output logic [NUM_OUTPUTS-1:0] offsetApplied, // pulse per output on apply
   output stpo_pkg::stpo_offset_t [NUM_OUTPUTS-1:0] auxTimePayloadOffset // payload fields
);
   typedef struct packed {
      stpo_pkg::stpo_chan_t [NUM_OUTPUTS-1:0] chan;
      stpo_pkg::stpo_offset_t viewOfs;
      logic viewArm;
      logic viewImm;
      logic [NUM_OUTPUTS-1:0] appliedPulse;
      stpo_pkg::stpo_offset_t [NUM_OUTPUTS-1:0] payloadOfs;
   } stpo_st_t;
   // every flop of the block lives in this one struct
   stpo_st_t state_reg;
   stpo_st_t state_next;
   logic [NUM_OUTPUTS-1:0] sel;
   logic [NUM_OUTPUTS-1:0] reached;
   logic [NUM_OUTPUTS-1:0] fireNow;
   logic inRangeImm;
   logic inRangeSch;
   logic signed [`STPO_OFS_W-1:0] pv;
   assign pv = pendingOffsetValue.value;
   assign inRangeImm = (pv <= $signed(`STPO_IMM_MAX)) && (pv >= -$signed(`STPO_IMM_MAX));
   // scheduled range check
   // the limit follows the arm state at write time, not at the firing
   assign inRangeSch = (pv <= $signed(`STPO_SCH_MAX)) && (pv >= -$signed(`STPO_SCH_MAX));
   genvar g;
   generate
      for (g = 0; g < NUM_OUTPUTS; g++) begin : gen_chan
         assign sel[g] = (outputSelector == `STPO_SEL_W'(g));
         // one-second compare
         // exact match only: a local clock that skips this second misses the schedule
         assign reached[g] = (localTime == state_reg.chan[g].schedTime) &&
                             (localDate == state_reg.chan[g].schedDate);
         assign fireNow[g] = state_reg.chan[g].armed && reached[g];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      // pulses stand for one cycle only
      state_next.appliedPulse = '0;
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
         // writes to a disabled output are dropped; enabling first is the caller's job
         // gate on output enable
         if (sel[i] && outputEnable[i]) begin
            if (pendingWrite) begin
               if (state_reg.chan[i].armed ? inRangeSch : inRangeImm) begin
                  state_next.chan[i].pending = pendingOffsetValue;
               end
            end
            if (schedWrite) begin
               state_next.chan[i].schedTime = scheduledApplyTime;
               state_next.chan[i].schedDate = scheduledApplyDate;
               state_next.chan[i].immFlag = 1'b0;
            end
            if (armWrite) begin
               state_next.chan[i].armed = scheduledApplyArm;
               if (scheduledApplyArm) begin
                  state_next.chan[i].immFlag = 1'b0;
               end
            end
            // an arm-on or schedule write in the same cycle beats the immediate write
            // ignore immediate while armed
            if (immFlagWrite && !state_reg.chan[i].armed && !schedWrite && !(armWrite && scheduledApplyArm)) begin
               state_next.chan[i].immFlag = immediateApplyFlag;
            end
         end
         // the flag stays on, so later pending writes reach the payload too
         // immediate apply follows pending while flag is on
         if (state_reg.chan[i].immFlag && !state_reg.chan[i].armed) begin
            state_next.chan[i].applied = state_reg.chan[i].pending;
            state_next.payloadOfs[i] = state_reg.chan[i].pending;
            state_next.appliedPulse[i] = state_reg.chan[i].applied != state_reg.chan[i].pending;
         end
         if (fireNow[i]) begin
            state_next.chan[i].applied = state_reg.chan[i].pending;
            state_next.payloadOfs[i] = state_reg.chan[i].pending;
            state_next.chan[i].armed = 1'b0;
            state_next.appliedPulse[i] = 1'b1;
         end
      end
      // views lag one edge so each output comes straight from a flop
      state_next.viewOfs = state_reg.chan[outputSelector].applied;
      state_next.viewArm = state_reg.chan[outputSelector].armed;
      state_next.viewImm = state_reg.chan[outputSelector].immFlag;
   end
   // async clear only; the whole struct reloads on every edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   // every output is a bit of the state flops
   assign appliedOffsetView = state_reg.viewOfs;
   assign armView = state_reg.viewArm;
   assign immView = state_reg.viewImm;
   assign offsetApplied = state_reg.appliedPulse;
   assign auxTimePayloadOffset = state_reg.payloadOfs;
   ////////////////////////////////////////////////////////////////////////
   // per-output checks, so whichever outputs a test touches get watched
   genvar c;
   generate
      for (c = 0; c < NUM_OUTPUTS; c++) begin : gen_chk
         AST_DISARM: assert property (@(posedge clk) disable iff (!reset_n)
            fireNow[c] |=> !state_reg.chan[c].armed && offsetApplied[c])
            else $error("arm not cleared after scheduled apply");
         AST_SCHED_VAL: assert property (@(posedge clk) disable iff (!reset_n)
            fireNow[c] |=> auxTimePayloadOffset[c] == $past(state_reg.chan[c].pending))
            else $error("payload offset not pending after schedule");
         AST_VIEW: assert property (@(posedge clk) disable iff (!reset_n)
            offsetApplied[c] && sel[c] |=> appliedOffsetView == $past(auxTimePayloadOffset[c]))
            else $error("applied view stale");
         AST_IMM_OFF: assert property (@(posedge clk) disable iff (!reset_n)
            state_reg.chan[c].armed |-> !state_reg.chan[c].immFlag)
            else $error("immediate flag set while armed");
         AST_IMM_APPLY: assert property (@(posedge clk) disable iff (!reset_n)
            state_reg.chan[c].immFlag && !state_reg.chan[c].armed |=>
               auxTimePayloadOffset[c] == $past(state_reg.chan[c].pending))
            else $error("immediate apply missed");
         AST_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
            !state_reg.chan[c].immFlag && !fireNow[c] |=> $stable(auxTimePayloadOffset[c]))
            else $error("offset changed without apply");
         AST_SCH_CLR_IMM: assert property (@(posedge clk) disable iff (!reset_n)
            schedWrite && sel[c] && outputEnable[c] |=> !state_reg.chan[c].immFlag)
            else $error("schedule write left immediate on");
         AST_RANGE: assert property (@(posedge clk) disable iff (!reset_n)
            pendingWrite && sel[c] && outputEnable[c] && !inRangeImm |=> $stable(state_reg.chan[c].pending))
            else $error("out of range offset accepted");
         AST_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
            pendingWrite && sel[c] && !outputEnable[c] |=> $stable(state_reg.chan[c].pending))
            else $error("disabled output took a write");
         AST_RANGE_SCH: assert property (@(posedge clk) disable iff (!reset_n)
            pendingWrite && sel[c] && outputEnable[c] && state_reg.chan[c].armed && !inRangeSch |=>
               $stable(state_reg.chan[c].pending))
            else $error("scheduled offset out of range accepted");
         AST_ONCE: assert property (@(posedge clk) disable iff (!reset_n)
            !state_reg.chan[c].armed && !state_reg.chan[c].immFlag |=> !offsetApplied[c])
            else $error("offset applied with nothing armed");
         AST_SCHED_STORE: assert property (@(posedge clk) disable iff (!reset_n)
            schedWrite && sel[c] && outputEnable[c] |=> state_reg.chan[c].schedTime == $past(scheduledApplyTime) &&
               state_reg.chan[c].schedDate == $past(scheduledApplyDate))
            else $error("schedule not stored");
         AST_PEND_STORE: assert property (@(posedge clk) disable iff (!reset_n)
            pendingWrite && sel[c] && outputEnable[c] && !state_reg.chan[c].armed && inRangeImm |=>
               state_reg.chan[c].pending == $past(pendingOffsetValue))
            else $error("valid pending offset not stored");
         AST_IMM_IGNORE: assert property (@(posedge clk) disable iff (!reset_n)
            immFlagWrite && sel[c] && state_reg.chan[c].armed |=> !state_reg.chan[c].immFlag)
            else $error("immediate flag taken while armed");
         AST_IMM_GATE: assert property (@(posedge clk) disable iff (!reset_n)
            immFlagWrite && sel[c] && !outputEnable[c] |=> $stable(state_reg.chan[c].immFlag))
            else $error("disabled output took a flag write");
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////
   // main scenarios: scheduled firing, immediate tracking, arming, refusals
   COV_SCHED: cover property (@(posedge clk) disable iff (!reset_n) |fireNow);
   COV_IMM: cover property (@(posedge clk) disable iff (!reset_n) state_reg.viewImm && |offsetApplied);
   COV_ARM: cover property (@(posedge clk) disable iff (!reset_n) armWrite && scheduledApplyArm);
   COV_REFUSED: cover property (@(posedge clk) disable iff (!reset_n) pendingWrite && inRangeImm && !inRangeSch);
   COV_DISABLED: cover property (@(posedge clk) disable iff (!reset_n) pendingWrite && !(|(sel & outputEnable)));
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the scheduled payload offset block
`timescale 1ns/100ps
module testbench;
   logic clk = 0, reset_n = 0, pendingWrite = 0, immFlagWrite = 0, immediateApplyFlag = 0;
   logic schedWrite = 0, armWrite = 0, scheduledApplyArm = 0, armView, immView;
   logic [1:0] outputSelector = 2'h0;
   logic [3:0] outputEnable = 4'h7; // outputs 0 to 2 enabled before any write
   logic [3:0] offsetApplied;
   stpo_pkg::stpo_offset_t pendingOffsetValue = '0, appliedOffsetView;
   stpo_pkg::stpo_time_t scheduledApplyTime = '0, localTime = '0;
   stpo_pkg::stpo_date_t scheduledApplyDate = '0, localDate = '0;
   stpo_pkg::stpo_offset_t [3:0] auxTimePayloadOffset;
   int nMismatch = 0, comparisons = 0;
   stpo_top uut (.clk(clk), .reset_n(reset_n), .outputSelector(outputSelector), .outputEnable(outputEnable),
      .pendingWrite(pendingWrite), .pendingOffsetValue(pendingOffsetValue), .immFlagWrite(immFlagWrite),
      .immediateApplyFlag(immediateApplyFlag), .schedWrite(schedWrite), .scheduledApplyTime(scheduledApplyTime),
      .scheduledApplyDate(scheduledApplyDate), .armWrite(armWrite), .scheduledApplyArm(scheduledApplyArm),
      .localTime(localTime), .localDate(localDate), .appliedOffsetView(appliedOffsetView), .armView(armView),
      .immView(immView), .offsetApplied(offsetApplied), .auxTimePayloadOffset(auxTimePayloadOffset));
   initial begin
      forever #5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [27:0] seen, input logic [27:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // inputs move 1 ns after the edge so the design never samples a changing value
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic setPending(input logic [1:0] sel, input logic [24:0] v, input logic [2:0] u);
      outputSelector = sel;
      pendingOffsetValue = {v, u};
      pendingWrite = 1'b1;
      step(1);
      pendingWrite = 1'b0;
   endtask
   // one task for both flags: arm selects the scheduled arm, else the immediate flag
   task automatic ctl(input logic [1:0] sel, input logic arm, input logic flag);
      outputSelector = sel;
      immediateApplyFlag = flag;
      scheduledApplyArm = flag;
      immFlagWrite = !arm;
      armWrite = arm;
      step(1);
      immFlagWrite = 1'b0;
      armWrite = 1'b0;
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", nMismatch, comparisons);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      step(2);
      reset_n = 1'b1;
      check(auxTimePayloadOffset[1], 28'h0);
      setPending(2'h1, 25'h1676981, 3'h2);
      ctl(2'h1, 1'b0, 1'b1);
      step(3);
      check(auxTimePayloadOffset[1], {25'h1676981, 3'h2});
      check(appliedOffsetView, {25'h1676981, 3'h2});
      setPending(2'h1, 25'h0989680, 3'h1);
      step(3);
      check(auxTimePayloadOffset[1], {25'h1676981, 3'h2});
      setPending(2'h1, 25'h098967F, 3'h1);
      step(3);
      check(auxTimePayloadOffset[1], {25'h098967F, 3'h1});
      ctl(2'h1, 1'b0, 1'b0);
      setPending(2'h1, 25'h0000005, 3'h1);
      step(3);
      check(auxTimePayloadOffset[1], {25'h098967F, 3'h1});
      setPending(2'h1, 25'h0, 3'h0);
      ctl(2'h1, 1'b0, 1'b1);
      step(3);
      check(auxTimePayloadOffset[1], 28'h0);
      // output 3 is disabled, so its writes must be dropped
      setPending(2'h3, 25'h0000007, 3'h1);
      ctl(2'h3, 1'b0, 1'b1);
      step(3);
      check(auxTimePayloadOffset[3], 28'h0);
      check(auxTimePayloadOffset[0], 28'h0);
      // immediate flag on, then a schedule write must drop it
      ctl(2'h2, 1'b0, 1'b1);
      step(1);
      check({27'h0, immView}, 28'h1);
      scheduledApplyTime = '{sec: 6'h1E, min: 6'h2D, hour: 5'h0C};
      scheduledApplyDate = '{year: 14'h07E9, month: 4'h6, day: 5'h0F};
      schedWrite = 1'b1;
      step(1);
      schedWrite = 1'b0;
      step(2);
      check({27'h0, immView}, 28'h0);
      // armed before the offsets go in, so the tighter limit refuses the second one
      ctl(2'h2, 1'b1, 1'b1);
      setPending(2'h2, 25'h001869F, 3'h3);
      setPending(2'h2, 25'h00186A0, 3'h3);
      ctl(2'h2, 1'b0, 1'b1);
      step(3);
      check({27'h0, armView}, 28'h1);
      check({27'h0, immView}, 28'h0);
      check(auxTimePayloadOffset[2], 28'h0);
      localTime = scheduledApplyTime;
      localDate = scheduledApplyDate;
      for (int i = 0; i < 5 && offsetApplied[2] !== 1'b1; i++) step(1);
      check({27'h0, offsetApplied[2]}, 28'h1);
      check(auxTimePayloadOffset[2], {25'h001869F, 3'h3});
      step(3);
      check({27'h0, armView}, 28'h0);
      check(appliedOffsetView, {25'h001869F, 3'h3});
      // time still matches: a second firing would show up here
      setPending(2'h2, 25'h0000009, 3'h3);
      step(3);
      check(auxTimePayloadOffset[2], {25'h001869F, 3'h3});
      finish_test();
   end
   // the sequence needs about 50 cycles; 2000 leaves ample margin
   initial begin
      #20000;
      nMismatch++;
      finish_test();
   end
endmodule
